// ---- pkg/hec_pkg.sv ----
// Shared constants and carrier types of the HDLC event and count register block
package hec_pkg;

  // ---------------------------------------------------------------
  // Register offsets on the parallel microprocessor port
  // ---------------------------------------------------------------
  localparam logic [4:0] HEC_OFF_INT_MASK   = 5'h16;
  localparam logic [4:0] HEC_OFF_EVENTS     = 5'h17;
  localparam logic [4:0] HEC_OFF_CHECK_UPPER = 5'h18;
  localparam logic [4:0] HEC_OFF_CHECK_LOWER = 5'h19;
  localparam logic [4:0] HEC_OFF_TX_LENGTH  = 5'h1A;

  // ---------------------------------------------------------------
  // Event register bit positions
  // ---------------------------------------------------------------
  localparam int HEC_BIT_GO_AHEAD   = 7;
  localparam int HEC_BIT_RX_END     = 6;
  localparam int HEC_BIT_TX_DONE    = 5;
  localparam int HEC_BIT_RX_LAST    = 4;
  localparam int HEC_BIT_TX_LOW     = 3;
  localparam int HEC_BIT_ABORT_UNDR = 2;
  localparam int HEC_BIT_RX_HIGH    = 1;
  localparam int HEC_BIT_RX_OVERRUN = 0;

  // ---------------------------------------------------------------
  // Reset values and unmapped read value
  // ---------------------------------------------------------------
  localparam logic [7:0] HEC_RST_EVENTS   = 8'h00;
  localparam logic [7:0] HEC_RST_MASK     = 8'h00;
  localparam logic [7:0] HEC_RST_CHECK    = 8'h00;
  localparam logic [7:0] HEC_RST_LENGTH   = 8'h00;
  localparam logic [7:0] HEC_READ_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // Receive FIFO size, abort qualification and last transmit length count
  // ---------------------------------------------------------------
  localparam logic [7:0] HEC_RX_FIFO_DEPTH  = 8'h80;
  localparam logic [4:0] HEC_ABORT_MIN_BITS = 5'h1A;
  localparam logic [7:0] HEC_LENGTH_LAST    = 8'h01;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        goAhead;      // Go-ahead pattern recognised
    logic        packetEnd;    // Packet-end byte written into the RX FIFO
    logic        lastNext;     // Next byte to read closes a packet
    logic        emptyRead;    // Host read of an empty RX FIFO
    logic        flagSeen;     // Flag sequence detected
    logic        bitTick;      // One bit of the current packet received
    logic        abortSeen;    // Abort sequence received
    logic        fifoWrite;    // Receiver writes one byte to the RX FIFO
    logic [7:0]  level;        // RX FIFO occupancy, 0 to 128
    logic [7:0]  fullThresh;   // Programmed full threshold
    logic [15:0] checkSeq;     // Received check sequence, as sent
  } hec_rx_evt_s;

  typedef struct packed {
    logic       packetDone;    // Closing flag sent or packet aborted
    logic       fetch;         // Transmitter fetches a byte from the TX FIFO
    logic       fifoWrite;     // Host write into the TX FIFO completes
    logic [7:0] level;         // TX FIFO occupancy
    logic [7:0] lowThresh;     // Programmed low threshold
  } hec_tx_evt_s;

  typedef enum logic {
    HEC_RX_RUNNING,
    HEC_RX_HALTED
  } hec_rx_state_e;

endpackage

// ---- hw/hec_event_flags.sv ----
// Sticky event flags, cleared by read, where a new event wins over the clear
module hec_event_flags (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] setVec,
  input  wire logic       clearAll,
  output logic      [7:0] flags
);
  import hec_pkg::*;

  // ---------------------------------------------------------------
  // One flip-flop per flag
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gFlag
      logic flagNext;
      // Set beats clear so no event is lost in the read cycle
      assign flagNext = setVec[i] | (flags[i] & ~clearAll);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[i] <= HEC_RST_EVENTS[i];
        end else begin
          flags[i] <= flagNext;
        end
      end
    end
  endgenerate

endmodule

// ---- hw/hec_tx_length.sv ----
// Transmit length counter that marks the packet-end byte of TX FIFO writes
module hec_tx_length (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] loadValue,
  input  wire logic       fifoWrite,
  input  wire logic       cycleReload,
  output logic      [7:0] count,
  output logic            packetEndTag
);
  import hec_pkg::*;

  logic [7:0] length_reg;
  logic [7:0] count_next;
  logic       atLast;

  // ---------------------------------------------------------------
  // Next count: load, then decrement per write, reload when cycling
  // ---------------------------------------------------------------
  assign atLast       = (count == HEC_LENGTH_LAST);
  assign packetEndTag = atLast;
  assign count_next   = load ? loadValue :
                        !fifoWrite ? count :
                        (atLast && cycleReload) ? length_reg :
                        (count == 8'h00) ? count :
                        count - 8'h01;

  // Counter and programmed length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count      <= HEC_RST_LENGTH;
      length_reg <= HEC_RST_LENGTH;
    end else begin
      count <= count_next;
      if (load) begin
        length_reg <= loadValue;
      end
    end
  end

endmodule

// ---- hw/hec_regs.sv ----
// HDLC event flags, check-sequence capture and transmit length registers
//
// Overview of operation
// - Go-ahead pattern sets bit 7.
// - Each receive packet-end byte sets bit 6.
// - Closing flag sent or abort sets bit 5.
// - Next byte last, or empty read, sets bit 4.
// - TX FIFO falling under low threshold sets bit 3.
// - Bit 2 is abort or underrun by select.
// - Abort counts only after 26 received bits.
// - Underrun mode: fetch from empty FIFO sets bit 2.
// - RX FIFO rising above full threshold sets bit 1.
// - Write to full 128-byte FIFO while receiver runs sets bit 0.
// - Overflow always disables the receiver.
// - Next flag re-enables the receiver.
// - Reading event register clears all flags except those set again in the same cycle.
// - Upper capture holds upper check byte as received.
// - Lower capture holds lower check byte as received.
// - Both captures update at every packet end.
// - Count of one tags next FIFO write.
// - Counter decrements after each FIFO write, holding at zero.
// - Reload control repeats the programmed length.
// - Masked events set flags, not the pin.
// - Mask register clears on reset.
module hec_regs (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // Parallel microprocessor port
  input  wire logic                 cs_n,
  input  wire logic                 rd_n,
  input  wire logic                 wr_n,
  input  wire logic [4:0]           addr,
  input  wire logic [7:0]           dataIn,
  output logic      [7:0]           dataOut,
  output logic                      dataOe_n,
  output logic                      irq_n,
  // Control bits kept outside this block
  input  wire logic                 intSel,
  input  wire logic                 cycleReload,
  // HDLC receiver and transmitter events
  input  wire hec_pkg::hec_rx_evt_s rxEvt,
  input  wire hec_pkg::hec_tx_evt_s txEvt,
  // Results towards the HDLC core
  output logic                      rxEnable,
  output logic                      txPacketEndTag
);
  import hec_pkg::*;

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  logic rstMeta_reg;
  logic rstN;

  // Asynchronous assert, release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstN        <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN        <= rstMeta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Bus access decode
  // ---------------------------------------------------------------
  logic       rdActive;
  logic       wrActive;
  logic       rdActive_reg;
  logic       wrActive_reg;
  logic       rdStart;
  logic       wrStart;
  logic       selMask;
  logic       selEvents;
  logic       selUpper;
  logic       selLower;
  logic       selLength;

  // Access strobes, taken on the first cycle of each access
  assign rdActive = ~cs_n & ~rd_n;
  assign wrActive = ~cs_n & ~wr_n;
  assign rdStart  = rdActive & ~rdActive_reg;
  assign wrStart  = wrActive & ~wrActive_reg;

  // Address match per register
  assign selMask   = (addr == HEC_OFF_INT_MASK);
  assign selEvents = (addr == HEC_OFF_EVENTS);
  assign selUpper  = (addr == HEC_OFF_CHECK_UPPER);
  assign selLower  = (addr == HEC_OFF_CHECK_LOWER);
  assign selLength = (addr == HEC_OFF_TX_LENGTH);

  // Previous access level for edge detection
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdActive_reg <= 1'b0;
      wrActive_reg <= 1'b0;
    end else begin
      rdActive_reg <= rdActive;
      wrActive_reg <= wrActive;
    end
  end

  // ---------------------------------------------------------------
  // Receive abort qualification
  // ---------------------------------------------------------------
  logic [4:0] rxBits_reg;
  logic [4:0] rxBits_next;
  logic       rxBitsEnough;
  logic       abortEvt;

  // Bits counted since the last flag, saturating at the minimum
  assign rxBitsEnough = (rxBits_reg >= HEC_ABORT_MIN_BITS);
  assign rxBits_next  = rxEvt.flagSeen ? 5'h00 :
                        (rxEvt.bitTick && !rxBitsEnough) ? rxBits_reg + 5'h01 :
                        rxBits_reg;
  assign abortEvt     = rxEvt.abortSeen & rxBitsEnough;

  // Packet bit counter
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxBits_reg <= 5'h00;
    end else begin
      rxBits_reg <= rxBits_next;
    end
  end

  // ---------------------------------------------------------------
  // Receive overflow and receiver enable
  // ---------------------------------------------------------------
  hec_rx_state_e rxState_reg;
  hec_rx_state_e rxState_next;
  logic          overflowEvt;

  // A write into a FIFO that already holds every location
  assign overflowEvt = rxEvt.fifoWrite & (rxEvt.level == HEC_RX_FIFO_DEPTH) &
                       (rxState_reg == HEC_RX_RUNNING);

  // Receiver halts on overflow until the next flag
  always_comb begin
    rxState_next = rxState_reg;
    case (rxState_reg)
      HEC_RX_RUNNING: begin
        if (overflowEvt) begin
          rxState_next = HEC_RX_HALTED;
        end
      end
      HEC_RX_HALTED: begin
        if (rxEvt.flagSeen) begin
          rxState_next = HEC_RX_RUNNING;
        end
      end
      default: begin
        rxState_next = HEC_RX_RUNNING;
      end
    endcase
  end

  // Receiver state register
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxState_reg <= HEC_RX_RUNNING;
    end else begin
      rxState_reg <= rxState_next;
    end
  end

  // Enable goes low the cycle after the overflowing write
  assign rxEnable = (rxState_reg == HEC_RX_RUNNING);

  // ---------------------------------------------------------------
  // FIFO threshold crossings
  // ---------------------------------------------------------------
  logic txLow;
  logic txLow_reg;
  logic rxHigh;
  logic rxHigh_reg;
  logic txLowEvt;
  logic rxHighEvt;
  logic underrunEvt;

  // Level comparisons against the programmed thresholds
  assign txLow       = (txEvt.level < txEvt.lowThresh);
  assign rxHigh      = (rxEvt.level > rxEvt.fullThresh);
  assign txLowEvt    = txLow & ~txLow_reg;
  assign rxHighEvt   = rxHigh & ~rxHigh_reg;
  assign underrunEvt = txEvt.fetch & (txEvt.level == 8'h00);

  // Previous comparison results; start as not crossed
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      txLow_reg  <= 1'b0;
      rxHigh_reg <= 1'b0;
    end else begin
      txLow_reg  <= txLow;
      rxHigh_reg <= rxHigh;
    end
  end

  // ---------------------------------------------------------------
  // Event flag register
  // ---------------------------------------------------------------
  logic [7:0] eventSet;
  logic [7:0] eventFlags;
  logic       eventClear;

  // Per-bit set sources
  always_comb begin
    eventSet                     = 8'h00;
    eventSet[HEC_BIT_GO_AHEAD]   = rxEvt.goAhead;
    eventSet[HEC_BIT_RX_END]     = rxEvt.packetEnd;
    eventSet[HEC_BIT_TX_DONE]    = txEvt.packetDone;
    eventSet[HEC_BIT_RX_LAST]    = rxEvt.lastNext | rxEvt.emptyRead;
    eventSet[HEC_BIT_TX_LOW]     = txLowEvt;
    eventSet[HEC_BIT_ABORT_UNDR] = intSel ? underrunEvt : abortEvt;
    eventSet[HEC_BIT_RX_HIGH]    = rxHighEvt;
    eventSet[HEC_BIT_RX_OVERRUN] = overflowEvt;
  end

  // Any read of the event register clears it
  assign eventClear = rdStart & selEvents;

  hec_event_flags uFlags (
    .clk      (mclk),
    .rst_n    (rstN),
    .setVec   (eventSet),
    .clearAll (eventClear),
    .flags    (eventFlags)
  );

  // ---------------------------------------------------------------
  // Interrupt mask and pin
  // ---------------------------------------------------------------
  logic [7:0] mask_reg;
  logic       irqAny;

  // Mask register, cleared at reset so all events start disabled
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      mask_reg <= HEC_RST_MASK;
    end else if (wrStart && selMask) begin
      mask_reg <= dataIn;
    end
  end

  // Masked events still hold their flag but leave the pin high
  assign irqAny = |(eventFlags & mask_reg);

  // Pin driven from a flop
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~irqAny;
    end
  end

  // ---------------------------------------------------------------
  // Check-sequence capture
  // ---------------------------------------------------------------
  logic [7:0] checkUpper_reg;
  logic [7:0] checkLower_reg;

  // Both bytes kept as sent, not inverted, at every packet end
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      checkUpper_reg <= HEC_RST_CHECK;
      checkLower_reg <= HEC_RST_CHECK;
    end else if (rxEvt.packetEnd) begin
      checkUpper_reg <= rxEvt.checkSeq[15:8];
      checkLower_reg <= rxEvt.checkSeq[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Transmit length counter
  // ---------------------------------------------------------------
  logic [7:0] txLength;
  logic       lengthLoad;

  // Host write of the packet length
  assign lengthLoad = wrStart & selLength;

  hec_tx_length uLength (
    .clk          (mclk),
    .rst_n        (rstN),
    .load         (lengthLoad),
    .loadValue    (dataIn),
    .fifoWrite    (txEvt.fifoWrite),
    .cycleReload  (cycleReload),
    .count        (txLength),
    .packetEndTag (txPacketEndTag)
  );

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  logic [7:0] readMux;

  // Register select for reads; unmapped offsets read as zero
  always_comb begin
    if (selMask) begin
      readMux = mask_reg;
    end else if (selEvents) begin
      readMux = eventFlags;
    end else if (selUpper) begin
      readMux = checkUpper_reg;
    end else if (selLower) begin
      readMux = checkLower_reg;
    end else if (selLength) begin
      readMux = txLength;
    end else begin
      readMux = HEC_READ_UNMAPPED;
    end
  end

  // Read data captured on the first cycle of the read
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      dataOut <= 8'h00;
    end else if (rdStart) begin
      dataOut <= readMux;
    end
  end

  // Drive the data bus from the second cycle of the read strobe until it ends
  assign dataOe_n = ~(rdActive & rdActive_reg);

endmodule

// ---- verif/hec_regs_assertions.sv ----
// Concurrent checks on the ports of the HDLC event and count register block
module hec_regs_assertions (
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire logic                 cs_n,
  input wire logic                 rd_n,
  input wire logic                 wr_n,
  input wire logic [4:0]           addr,
  input wire logic [7:0]           dataIn,
  input wire logic [7:0]           dataOut,
  input wire logic                 dataOe_n,
  input wire logic                 irq_n,
  input wire logic                 cycleReload,
  input wire hec_pkg::hec_rx_evt_s rxEvt,
  input wire hec_pkg::hec_tx_evt_s txEvt,
  input wire logic                 rxEnable,
  input wire logic                 txPacketEndTag
);
  timeunit 1ns;
  timeprecision 1ps;
  import hec_pkg::*;

  logic        busAct_reg;
  logic        maskSeen_reg;
  logic [15:0] cap_reg;

  // Start of a bus access and absence of flag-setting pulses
  wire busAct  = !cs_n && (!rd_n || !wr_n);
  wire rdStart = !cs_n && !rd_n && !busAct_reg;
  wire wrStart = !cs_n && !wr_n && !busAct_reg;
  wire noEvt   = !(|rxEvt[39:32]) && !(|txEvt[18:16]);

  // Shadow of bus activity, mask writes and the captured check sequence
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busAct_reg   <= 1'b0;
      maskSeen_reg <= 1'b0;
      cap_reg      <= 16'h0000;
    end else begin
      busAct_reg <= busAct;
      if (wrStart && addr == HEC_OFF_INT_MASK) maskSeen_reg <= 1'b1;
      if (rxEvt.packetEnd) cap_reg <= rxEvt.checkSeq;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  chk_overflow_halt: assert property (
    rxEvt.fifoWrite && rxEvt.level == HEC_RX_FIFO_DEPTH && rxEnable |=> !rxEnable)
    else $error("receiver still enabled after overflow");
  chk_halt_holds: assert property (
    !rxEnable && !rxEvt.flagSeen |=> !rxEnable)
    else $error("receiver resumed without a flag");
  chk_flag_resume: assert property (
    !rxEnable && rxEvt.flagSeen |=> rxEnable)
    else $error("receiver not resumed by flag");
  chk_tag_load: assert property (
    wrStart && addr == HEC_OFF_TX_LENGTH |=> txPacketEndTag == ($past(dataIn) == 8'h01))
    else $error("end tag wrong after length write");
  chk_tag_drop: assert property (
    txPacketEndTag && txEvt.fifoWrite && !cycleReload && !wrStart |=> !txPacketEndTag)
    else $error("end tag kept after last write");
  chk_cap_upper: assert property (
    rdStart && addr == HEC_OFF_CHECK_UPPER && !rxEvt.packetEnd |=> dataOut == cap_reg[15:8])
    else $error("upper check byte wrong");
  chk_cap_lower: assert property (
    rdStart && addr == HEC_OFF_CHECK_LOWER && !rxEvt.packetEnd |=> dataOut == cap_reg[7:0])
    else $error("lower check byte wrong");
  chk_mask_reset: assert property (
    !maskSeen_reg |-> irq_n)
    else $error("interrupt before any mask write");
  chk_read_clear: assert property (
    rdStart && addr == HEC_OFF_EVENTS && noEvt ##1 noEvt |=> irq_n)
    else $error("interrupt kept after event read");
  chk_read_drive: assert property (
    !cs_n && !rd_n && busAct_reg |-> !dataOe_n)
    else $error("data bus not driven in held read");
  chk_bus_release: assert property (
    cs_n || rd_n || rdStart |-> dataOe_n)
    else $error("data bus driven outside a held read");
endmodule

bind hec_regs hec_regs_assertions hec_regs_assertions_i (
  .mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
  .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n), .irq_n(irq_n),
  .cycleReload(cycleReload),
  .rxEvt(rxEvt), .txEvt(txEvt), .rxEnable(rxEnable), .txPacketEndTag(txPacketEndTag)
);

// ---- verif/hec_host_model.sv ----
// Host microprocessor model driving the parallel register port
module hec_host_model (
  input  wire logic       mclk,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [4:0] addr,
  output logic      [7:0] dataIn,
  input  wire logic [7:0] dataOut
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    cs_n   = 1'b1;
    rd_n   = 1'b1;
    wr_n   = 1'b1;
    addr   = 5'h00;
    dataIn = 8'hA5;
  end

  // One access from a falling edge, held over the taking edge (reads one cycle longer),
  // then one idle cycle
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] wd,
                        output logic [7:0] rdv);
    cs_n   = 1'b0;
    rd_n   = w;
    wr_n   = !w;
    addr   = a;
    dataIn = w ? wd : ~dataIn;
    @(posedge mclk);
    @(negedge mclk);
    rdv    = dataOut;
    if (!w) begin
      @(negedge mclk); // Second read cycle drives the bus and repeats nothing
    end
    cs_n   = 1'b1;
    rd_n   = 1'b1;
    wr_n   = 1'b1;
    dataIn = ~dataIn; // Released data lines do not keep the last value
    @(negedge mclk);
  endtask
endmodule

// ---- verif/hec_regs_tb.sv ----
// Self-checking bench for the HDLC event, capture and length registers
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin nMismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module hec_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hec_pkg::*;

  logic        mclk, arst_n, intSel, cycleReload, cs_n, rd_n, wr_n;
  logic        dataOe_n, irq_n, rxEnable, txPacketEndTag;
  logic [4:0]  addr;
  logic [7:0]  dataIn, dataOut, d, mask, ef;
  hec_rx_evt_s rxEvt;
  hec_tx_evt_s txEvt;
  int          nMismatch, nCompared, cnt, len;

  hec_regs hec_regs_i (
    .mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n), .irq_n(irq_n),
    .intSel(intSel), .cycleReload(cycleReload), .rxEvt(rxEvt), .txEvt(txEvt),
    .rxEnable(rxEnable), .txPacketEndTag(txPacketEndTag));
  hec_host_model hec_host_model_i (
    .mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .dataIn(dataIn),
    .dataOut(dataOut));

  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #50000;
    nMismatch++;
    finishTest();
  end

  // ---------------------------------------------------------------
  // Bus, pulse and model tasks
  // ---------------------------------------------------------------
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    hec_host_model_i.access(1'b0, a, 8'h00, v);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] t;
    hec_host_model_i.access(1'b1, a, v, t);
  endtask
  // Event register read against the model, which then clears
  task automatic rdEv();
    logic [7:0] v;
    rd(HEC_OFF_EVENTS, v);
    `CHK(v, ef)
    ef = 8'h00;
  endtask
  // One-cycle pulse on a field, by order in the struct, then a gap cycle
  task automatic prx(input int k);
    rxEvt[39-k] = 1'b1;
    @(negedge mclk);
    rxEvt[39-k] = 1'b0;
    @(negedge mclk);
  endtask
  task automatic ptx(input int k);
    txEvt[18-k] = 1'b1;
    @(negedge mclk);
    txEvt[18-k] = 1'b0;
    @(negedge mclk);
  endtask
  task automatic finishTest();
    if (nMismatch == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    intSel = 1'b0;
    cycleReload = 1'b0;
    rxEvt = '0;
    rxEvt.fullThresh = 8'h40;
    txEvt = '0;
    txEvt.level = 8'hFF;
    txEvt.lowThresh = 8'h10;
    ef = 8'h00;
    nMismatch = 0;
    nCompared = 0;
    void'($urandom(94));
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    for (int a = 22; a < 28; a++) begin
      rd(5'(a), d);
      `CHK(d, 8'h00)
    end
    `CHK({irq_n, rxEnable, txPacketEndTag}, 3'h6)
    // Single events, masking, clear on read and check capture, twice
    for (int i = 0; i < 2; i++) begin
      mask = 8'($urandom);
      wr(HEC_OFF_INT_MASK, mask);
      rxEvt.checkSeq = 16'($urandom);
      for (int k = 0; k < 4; k++) if (k != 2 + i) prx(k);
      ptx(0);
      ef = 8'hF0;
      `CHK(irq_n, !(|(ef & mask)))
      rd(HEC_OFF_INT_MASK, d);
      `CHK(d, mask)
      rdEv();
      `CHK(irq_n, 1'b1)
      rdEv();
      rd(HEC_OFF_CHECK_UPPER, d);
      `CHK(d, rxEvt.checkSeq[15:8])
      wr(HEC_OFF_CHECK_LOWER, ~d);
      rd(HEC_OFF_CHECK_LOWER, d);
      `CHK(d, rxEvt.checkSeq[7:0])
    end
    // Threshold crossings
    rxEvt.level = 8'h41;
    txEvt.level = 8'h0F;
    @(negedge mclk);
    ef = 8'h0A;
    rdEv();
    // Abort qualification and underrun selection
    prx(4);
    repeat (25) prx(5);
    prx(6);
    rdEv();
    prx(5);
    prx(6);
    ef[2] = 1'b1;
    rdEv();
    intSel = 1'b1;
    txEvt.level = 8'h00;
    prx(6);
    ptx(1);
    ef[2] = 1'b1;
    rdEv();
    intSel = 1'b0;
    ptx(1);
    rdEv();
    // Overflow halts the receiver until the next flag
    rxEvt.level = HEC_RX_FIFO_DEPTH;
    prx(7);
    ef[0] = 1'b1;
    `CHK(rxEnable, 1'b0)
    rdEv();
    prx(7);
    rdEv();
    prx(4);
    `CHK(rxEnable, 1'b1)
    prx(7);
    ef[0] = 1'b1;
    rdEv();
    // Event in the cycle of the clearing read
    fork
      rd(HEC_OFF_EVENTS, d);
      prx(0);
    join
    `CHK(d, ef)
    ef[7] = 1'b1;
    rdEv();
    // Transmit length counter, plain and cycling
    len = 2 + $urandom % 4;
    wr(HEC_OFF_TX_LENGTH, 8'(len));
    cnt = len;
    repeat (len + 1) begin
      `CHK(txPacketEndTag, cnt == 1)
      ptx(2);
      cnt = cnt > 0 ? cnt - 1 : 0;
    end
    rd(HEC_OFF_TX_LENGTH, d);
    `CHK(d, 8'(cnt))
    cycleReload = 1'b1;
    wr(HEC_OFF_TX_LENGTH, 8'(len));
    cnt = len;
    repeat (2 * len + 1) begin
      `CHK(txPacketEndTag, cnt == 1)
      ptx(2);
      cnt = cnt == 1 ? len : cnt - 1;
    end
    rd(HEC_OFF_TX_LENGTH, d);
    `CHK(d, 8'(cnt))
    wr(HEC_OFF_TX_LENGTH, HEC_LENGTH_LAST);
    `CHK(txPacketEndTag, 1'b1)
    finishTest();
  end
endmodule
